/* File: hdl/qdic_pkg.sv */
// package: register map, field layout and constants of the encoder input block
package qdic_pkg;
   localparam logic [11:0] QDIC_OFS_IOCL = 12'h000;
   localparam logic [11:0] QDIC_OFS_CTRL = 12'h004;
   localparam logic [11:0] QDIC_OFS_POS = 12'h008;
   localparam logic [11:0] QDIC_OFS_LOW = 12'h00c;
   localparam logic [11:0] QDIC_OFS_HIGH = 12'h010;
   localparam logic [11:0] QDIC_OFS_CAP = 12'h014;
   localparam logic [11:0] QDIC_OFS_STAT = 12'h018;
   localparam logic [11:0] QDIC_OFS_MASK = 12'h01c;
   // io control field positions
   localparam int QDIC_B_CAPEN = 15;
   localparam int QDIC_B_FLTEN = 14;
   localparam int QDIC_B_FDIV = 11;
   localparam int QDIC_B_OFNC = 9;
   localparam int QDIC_B_SWAP = 8;
   localparam int QDIC_B_HPOL = 7;
   localparam int QDIC_B_IPOL = 6;
   localparam int QDIC_B_BPOL = 5;
   localparam int QDIC_B_APOL = 4;
   // control field positions
   localparam int QDIC_B_EXT_GATE_ENABLE = 2;
   localparam int QDIC_B_MODE = 0;
   // status bits
   localparam int QDIC_S_CAP = 0;
   localparam int QDIC_S_CMP = 1;
   localparam int QDIC_S_IDX = 2;
   localparam logic [15:0] QDIC_IOCL_RST = 16'h0000;
   localparam logic [2:0] QDIC_CTRL_RST = 3'h0;
   localparam logic [31:0] QDIC_POS_RST = 32'h00000000;
   localparam logic [31:0] QDIC_LOW_RST = 32'h00000000;
   localparam logic [31:0] QDIC_HIGH_RST = 32'hffffffff;
   localparam logic [2:0] QDIC_STAT_RST = 3'h0;
   localparam logic [2:0] QDIC_MASK_RST = 3'h0;
   localparam int QDIC_FLT_LEN = 3;
   typedef enum logic [1:0] {
      QDIC_MODE_QUAD = 2'b00,
      QDIC_MODE_UPDN = 2'b01,
      QDIC_MODE_EXTG = 2'b10,
      QDIC_MODE_TMRG = 2'b11
   } qdic_mode_t;
   typedef enum logic [1:0] {
      QDIC_OUT_OFF = 2'b00,
      QDIC_OUT_HIGH = 2'b01,
      QDIC_OUT_LOW = 2'b10,
      QDIC_OUT_BOTH = 2'b11
   } qdic_ofn_t;
endpackage

/* File: hdl/qdic_prescale.sv */
// filter clock prescaler: one tick every 2^code cycles
module qdic_prescale
   import qdic_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [2:0] code, // divide code 000..111
   output logic tick // one-cycle filter sample strobe
);
   logic [6:0] cnt;
   logic [6:0] next_cnt;
   logic [6:0] lim;
   always_comb begin
      lim = 7'((8'h01 << code) - 8'h01);
      tick = (cnt >= lim);
      next_cnt = tick ? 7'h00 : cnt + 7'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 7'h00;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule

/* File: hdl/qdic_filter.sv */
// digital input filter: output follows only after a stable run of samples
module qdic_filter
   import qdic_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic tick, // sample strobe from prescaler
   input wire logic din, // raw synchronous input
   output logic dout // filtered level
);
   logic [QDIC_FLT_LEN-1:0] hist;
   logic [QDIC_FLT_LEN-1:0] next_hist;
   logic next_dout;
   always_comb begin
      next_hist = hist;
      next_dout = dout;
      if (tick) begin
         next_hist = {hist[QDIC_FLT_LEN-2:0], din};
         if (&next_hist) begin
            next_dout = 1'b1;
         end else if (~|next_hist) begin
            next_dout = 1'b0;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist <= '0;
         dout <= 1'b0;
      end else begin
         hist <= next_hist;
         dout <= next_dout;
      end
   end
endmodule

/* File: hdl/qdic_top.sv */
// quadrature decoder input conditioning, counter modes and compare output
// Behaviour
// [RL1] gate enable set: external gate controls counting; clear: gate ignored
// [RL2] mode 11 timer+gate, 10 ext clock+gate, 01 ext clock+dir, 00 quadrature
// [RL3] capture enable set: rising index captures position; clear: no capture
// [RL4] filter enable inserts digital filter on A, B, index, home
// [RL5] filter clock divide code selects 1:1 up to 1:128, powers of two
// [RL6] compare output: 11 low or high limit, 10 low, 01 high, 00 off
// [RL7] swap bit exchanges phase A and B before the decoder
// [RL8] home polarity set inverts home input
// [RL9] index, B and A polarity bits invert their inputs likewise
// [RL10] low nibble reads current home, index, B, A levels after polarity and optional filter
module qdic_top
   import qdic_pkg::*;
(
   input wire logic pclk, // system clock 125 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic phase_a_input, // encoder phase a
   input wire logic phase_b_input, // encoder phase b
   input wire logic index_input, // encoder index
   input wire logic home_input, // home switch
   output logic compare_output_pin, // compare output
   output logic irq // level interrupt
);
   logic [15:0] encoder_io_control_low;
   logic [2:0] encoder_control;
   logic [31:0] position_counter;
   logic [31:0] low_compare_limit;
   logic [31:0] high_compare_limit;
   logic [31:0] capture;
   logic [2:0] status;
   logic [2:0] mask;
   logic [15:0] next_iocl;
   logic [2:0] next_ctrl;
   logic [31:0] next_pos;
   logic [31:0] next_low;
   logic [31:0] next_high;
   logic [31:0] next_cap;
   logic [2:0] next_status;
   logic [2:0] next_mask;
   logic [3:0] raw_pins;
   logic [3:0] polar;
   logic [3:0] filt;
   logic [3:0] cond;
   logic [3:0] prev;
   logic [3:0] next_prev;
   logic next_cmp;
   logic tick;
   logic wr;
   logic rd;
   logic hit;
   logic [2:0] evt;
   logic a_in;
   logic b_in;
   logic idx_rise;
   logic gate;
   logic step;
   logic dir;
   logic quad_err;
   logic [31:0] iocl_m;
   logic [31:0] ctrl_m;
   logic [31:0] mask_m;
   qdic_mode_t mode;
   qdic_ofn_t ofn;

   // byte-lane merge shared by every writable register except the write-one-clear status
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign mode = qdic_mode_t'(encoder_control[QDIC_B_MODE +: 2]);
   assign ofn = qdic_ofn_t'(encoder_io_control_low[QDIC_B_OFNC +: 2]);
   assign raw_pins = {home_input, index_input, phase_b_input, phase_a_input};
   // polarity applied before the filter so the filter sees final sense
   assign polar = raw_pins ^ {encoder_io_control_low[QDIC_B_HPOL], // RL8
                              encoder_io_control_low[QDIC_B_IPOL], // RL9
                              encoder_io_control_low[QDIC_B_BPOL],
                              encoder_io_control_low[QDIC_B_APOL]};

   qdic_prescale u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .code(encoder_io_control_low[QDIC_B_FDIV +: 3]), // RL5
      .tick(tick)
   );

   for (genvar g = 0; g < 4; g++) begin : g_flt
      qdic_filter u_flt (
         .pclk(pclk),
         .presetn(presetn),
         .tick(tick),
         .din(polar[g]),
         .dout(filt[g])
      );
   end

   // filter bypass still uses the filtered path's registers for nothing
   assign cond = encoder_io_control_low[QDIC_B_FLTEN] ? filt : polar; // RL4

   always_comb begin
      // swap ahead of the decoder only
      a_in = encoder_io_control_low[QDIC_B_SWAP] ? cond[1] : cond[0]; // RL7
      b_in = encoder_io_control_low[QDIC_B_SWAP] ? cond[0] : cond[1]; // RL7
      next_prev = {cond[3], cond[2], b_in, a_in};
   end

   always_comb begin
      idx_rise = cond[2] & ~prev[2];
      // home acts as the external gate input
      gate = encoder_control[QDIC_B_EXT_GATE_ENABLE] ? cond[3] : 1'b1; // RL1
      step = 1'b0;
      dir = 1'b1;
      quad_err = 1'b0;
      case (mode) // RL2
         QDIC_MODE_QUAD: begin
            // x4 decoding; both phases changing at once is a lost step
            if ((a_in ^ prev[0]) && (b_in ^ prev[1])) begin
               quad_err = 1'b1;
            end else if ((a_in ^ prev[0]) || (b_in ^ prev[1])) begin
               step = gate;
               dir = a_in ^ prev[1];
            end
         end
         QDIC_MODE_UPDN: begin
            step = a_in & ~prev[0] & gate;
            dir = b_in;
         end
         QDIC_MODE_EXTG: begin
            step = a_in & ~prev[0] & gate;
         end
         QDIC_MODE_TMRG: begin
            step = gate;
         end
         default: begin
            step = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_pos = position_counter;
      if (step) begin
         next_pos = dir ? position_counter + 32'h1 : position_counter - 32'h1;
      end
      // a software write to the counter wins over a count in the same cycle
      if (wr && paddr == QDIC_OFS_POS) begin
         next_pos = merge(position_counter, pwdata, pstrb);
      end
      next_cap = capture;
      if (encoder_io_control_low[QDIC_B_CAPEN] && idx_rise) begin // RL3
         next_cap = position_counter;
      end
      case (ofn) // RL6
         QDIC_OUT_BOTH: next_cmp = (position_counter <= low_compare_limit) ||
                                   (position_counter >= high_compare_limit);
         QDIC_OUT_LOW: next_cmp = position_counter <= low_compare_limit;
         QDIC_OUT_HIGH: next_cmp = position_counter >= high_compare_limit;
         default: next_cmp = 1'b0;
      endcase
   end

   // apb: zero wait states, write and read both complete in the access cycle
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         QDIC_OFS_IOCL, QDIC_OFS_CTRL, QDIC_OFS_POS, QDIC_OFS_LOW,
         QDIC_OFS_HIGH, QDIC_OFS_CAP, QDIC_OFS_STAT, QDIC_OFS_MASK:
            hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   assign evt[QDIC_S_CAP] = encoder_io_control_low[QDIC_B_CAPEN] & idx_rise;
   assign evt[QDIC_S_CMP] = next_cmp & ~compare_output_pin;
   assign evt[QDIC_S_IDX] = quad_err;

   // merged write words, narrowed to each register's width below
   assign iocl_m = merge({16'h0, encoder_io_control_low}, pwdata, pstrb);
   assign ctrl_m = merge({29'h0, encoder_control}, pwdata, pstrb);
   assign mask_m = merge({29'h0, mask}, pwdata, pstrb);

   always_comb begin
      next_iocl = encoder_io_control_low;
      next_ctrl = encoder_control;
      next_low = low_compare_limit;
      next_high = high_compare_limit;
      next_mask = mask;
      next_status = status;
      if (wr) begin
         case (paddr)
            QDIC_OFS_IOCL: next_iocl = {iocl_m[15:4], 4'h0};
            QDIC_OFS_CTRL: next_ctrl = ctrl_m[2:0];
            QDIC_OFS_LOW: next_low = merge(low_compare_limit, pwdata, pstrb);
            QDIC_OFS_HIGH: next_high = merge(high_compare_limit, pwdata, pstrb);
            QDIC_OFS_MASK: next_mask = mask_m[2:0];
            QDIC_OFS_STAT:
               if (pstrb[0]) begin
                  next_status = status & ~pwdata[2:0];
               end
            default: next_status = next_status;
         endcase
      end
      // a new event wins over a simultaneous write-one clear
      next_status = next_status | evt;
   end

   always_comb begin
      prdata = 32'h0;
      if (rd) begin
         case (paddr)
            QDIC_OFS_IOCL: // RL10
               prdata = {16'h0, encoder_io_control_low[15:4], cond};
            QDIC_OFS_CTRL: prdata = {29'h0, encoder_control};
            QDIC_OFS_POS: prdata = position_counter;
            QDIC_OFS_LOW: prdata = low_compare_limit;
            QDIC_OFS_HIGH: prdata = high_compare_limit;
            QDIC_OFS_CAP: prdata = capture;
            QDIC_OFS_STAT: prdata = {29'h0, status};
            QDIC_OFS_MASK: prdata = {29'h0, mask};
            default: prdata = 32'h0;
         endcase
      end
   end

   assign irq = |(status & mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         encoder_io_control_low <= QDIC_IOCL_RST;
         encoder_control <= QDIC_CTRL_RST;
         position_counter <= QDIC_POS_RST;
         low_compare_limit <= QDIC_LOW_RST;
         high_compare_limit <= QDIC_HIGH_RST;
         capture <= QDIC_POS_RST;
         status <= QDIC_STAT_RST;
         mask <= QDIC_MASK_RST;
         prev <= 4'h0;
         compare_output_pin <= 1'b0;
      end else begin
         encoder_io_control_low <= next_iocl;
         encoder_control <= next_ctrl;
         position_counter <= next_pos;
         low_compare_limit <= next_low;
         high_compare_limit <= next_high;
         capture <= next_cap;
         status <= next_status;
         mask <= next_mask;
         prev <= next_prev;
         compare_output_pin <= next_cmp;
      end
   end
endmodule

/* File: sim/qdic_props.sv */
// checker: port-level properties of the encoder input block
module qdic_props
   import qdic_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [11:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic [3:0] pstrb, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic pslverr, // apb
   input wire logic phase_a_input, // pin
   input wire logic phase_b_input, // pin
   input wire logic index_input, // pin
   input wire logic home_input, // pin
   input wire logic compare_output_pin, // pin
   input wire logic irq // interrupt
);
   logic [15:0] iocl;
   logic [15:0] next_iocl;
   logic msk0;
   logic next_msk0;
   logic [3:0] pins;
   logic [3:0] quiet;
   logic [3:0] next_quiet;
   logic wr;
   logic rd;
   logic [3:0] lvl;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign lvl = {home_input, index_input, phase_b_input, phase_a_input};
   // quiet counts cycles since the pins or the io control last moved
   always_comb begin
      next_iocl = iocl;
      next_msk0 = msk0;
      next_quiet = (quiet == 4'hf) ? quiet : quiet + 4'h1;
      if (wr && paddr == QDIC_OFS_IOCL) begin
         if (pstrb[1])
            next_iocl[15:8] = pwdata[15:8];
         if (pstrb[0])
            next_iocl[7:0] = pwdata[7:0];
         next_quiet = 4'h0;
      end
      if (wr && paddr == QDIC_OFS_MASK && pstrb[0])
         next_msk0 = (pwdata[2:0] == 3'h0);
      if (lvl != pins)
         next_quiet = 4'h0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iocl <= QDIC_IOCL_RST;
         msk0 <= 1'b1;
         pins <= 4'h0;
         quiet <= 4'h0;
      end else begin
         iocl <= next_iocl;
         msk0 <= next_msk0;
         pins <= lvl;
         quiet <= next_quiet;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // the pin is registered, so three quiet cycles cover its lag
   sequence s_out_off;
      iocl[10:9] == 2'b00 [*3];
   endsequence
   sequence s_irq_off;
      msk0 [*3];
   endsequence
   ready_high_a: assert property (pready)
      else $error("pready low");
   rdata_idle_a: assert property (!(psel && !pwrite) |-> prdata == 32'h0)
      else $error("read data not zero outside a read");
   err_unmapped_a: assert property (psel && penable
      && paddr > QDIC_OFS_MASK |-> pslverr) else $error("no error");
   err_mapped_a: assert property (psel && penable && paddr <= QDIC_OFS_MASK
      && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on register");
   ctl_read_a: assert property (rd && paddr == QDIC_OFS_IOCL
      |-> prdata[15:4] == iocl[15:4]) else $error("io control readback");
   pin_level_a: assert property (rd && paddr == QDIC_OFS_IOCL
      && quiet > 4'h7 && lvl == pins && !iocl[QDIC_B_FLTEN]
      |-> prdata[3:0] == (lvl ^ iocl[7:4])) else $error("pin levels wrong");
   cmp_off_a: assert property (s_out_off |-> !compare_output_pin)
      else $error("compare output driven while off");
   irq_masked_a: assert property (s_irq_off |-> !irq)
      else $error("interrupt raised while masked");
endmodule

/* File: sim/qdic_enc_model.sv */
// encoder model: quadrature phases plus index and home levels
module qdic_enc_model (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic step, // move one edge
   input wire logic rev, // move backwards
   input wire logic idx_lvl, // index level
   input wire logic home_lvl, // home level
   output logic a, // phase a
   output logic b, // phase b
   output logic idx, // index
   output logic home // home
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph;
   logic [1:0] next_ph;
   // forward runs ab 00,10,11,01: a leads b, one phase moves per step
   always_comb begin
      next_ph = ph;
      if (step)
         next_ph = rev ? ph - 2'h1 : ph + 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ph <= 2'h0;
      else
         ph <= next_ph;
   end
   assign a = ph[1] ^ ph[0];
   assign b = ph[1];
   assign idx = idx_lvl;
   assign home = home_lvl;
endmodule

/* File: sim/testbench.sv */
// testbench: registers, counter modes, capture, compare and filter
module testbench
   import qdic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic phase_a_input;
   logic phase_b_input;
   logic index_input;
   logic home_input;
   logic compare_output_pin;
   logic irq;
   logic step = 1'b0;
   logic rev = 1'b0;
   logic idx_lvl = 1'b0;
   logic home_lvl = 1'b0;
   logic [31:0] rv;
   logic ev;
   int error_cnt = 0;
   int checks = 0;
   always #4 pclk = ~pclk;
   qdic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
      .index_input(index_input), .home_input(home_input),
      .compare_output_pin(compare_output_pin), .irq(irq));
   qdic_enc_model enc (.pclk(pclk), .presetn(presetn), .step(step),
      .rev(rev), .idx_lvl(idx_lvl), .home_lvl(home_lvl), .a(phase_a_input),
      .b(phase_b_input), .idx(index_input), .home(home_input));
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, input logic [11:0] a,
      input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, e, rv);
   endtask
   task automatic steps(input int n, input logic r);
      repeat (n) begin
         @(posedge pclk);
         step <= 1'b1;
         rev <= r;
         @(posedge pclk);
         step <= 1'b0;
         repeat (6) @(posedge pclk);
      end
   endtask
   // a one-cycle pulse on phase a, too short for the filter
   task automatic glitch;
      @(posedge pclk);
      step <= 1'b1;
      rev <= 1'b0;
      @(posedge pclk);
      rev <= 1'b1;
      @(posedge pclk);
      step <= 1'b0;
      repeat (20) @(posedge pclk);
   endtask
   task automatic ipulse;
      @(posedge pclk);
      idx_lvl <= 1'b1;
      repeat (8) @(posedge pclk);
      idx_lvl <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   // two position reads lie three cycles apart
   task automatic tdiff(input logic [31:0] ct, input logic [31:0] io,
      input logic [31:0] e);
      logic [31:0] v;
      xfer(1'b1, QDIC_OFS_CTRL, ct);
      xfer(1'b1, QDIC_OFS_IOCL, io);
      repeat (8) @(posedge pclk);
      xfer(1'b0, QDIC_OFS_POS, 32'h0);
      v = rv;
      rdchk("timer", QDIC_OFS_POS, v + e);
   endtask
   task automatic t_regs;
      rdchk("ctrl", QDIC_OFS_CTRL, 32'h0);
      rdchk("low", QDIC_OFS_LOW, QDIC_LOW_RST);
      rdchk("high", QDIC_OFS_HIGH, QDIC_HIGH_RST);
      rdchk("stat", QDIC_OFS_STAT, 32'h0);
      rdchk("mask", QDIC_OFS_MASK, 32'h0);
      xfer(1'b0, 12'h020, 32'h0);
      chk("slverr", 32'h1, {31'h0, ev});
      pstrb <= 4'h1;
      xfer(1'b1, QDIC_OFS_HIGH, 32'h0);
      pstrb <= 4'hf;
      rdchk("strb", QDIC_OFS_HIGH, 32'hffffff00);
      xfer(1'b1, QDIC_OFS_IOCL, 32'hf);
      repeat (8) @(posedge pclk);
      rdchk("iocl", QDIC_OFS_IOCL, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_quad;
      xfer(1'b1, QDIC_OFS_POS, 32'h0);
      steps(8, 1'b0);
      rdchk("fwd", QDIC_OFS_POS, 32'h8);
      steps(4, 1'b1);
      rdchk("back", QDIC_OFS_POS, 32'h4);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h100);
      steps(4, 1'b0);
      rdchk("swap", QDIC_OFS_POS, 32'h0);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h0);
      $display("t_quad done");
   endtask
   task automatic t_modes;
      xfer(1'b1, QDIC_OFS_CTRL, 32'h1);
      steps(4, 1'b0);
      rdchk("updn", QDIC_OFS_POS, 32'hffffffff);
      steps(4, 1'b1);
      rdchk("updn back", QDIC_OFS_POS, 32'h0);
      xfer(1'b1, QDIC_OFS_CTRL, 32'h2);
      steps(4, 1'b0);
      steps(4, 1'b1);
      rdchk("extclk", QDIC_OFS_POS, 32'h2);
      xfer(1'b1, QDIC_OFS_CTRL, 32'h6);
      steps(4, 1'b0);
      rdchk("gate shut", QDIC_OFS_POS, 32'h2);
      tdiff(32'h7, 32'h0, 32'h0);
      tdiff(32'h7, 32'h80, 32'h3);
      tdiff(32'h3, 32'h0, 32'h3);
      xfer(1'b1, QDIC_OFS_CTRL, 32'h0);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h0);
      $display("t_modes done");
   endtask
   task automatic t_cap;
      xfer(1'b1, QDIC_OFS_STAT, 32'h7);
      xfer(1'b1, QDIC_OFS_POS, 32'h1234);
      ipulse;
      rdchk("no cap", QDIC_OFS_STAT, 32'h0);
      xfer(1'b1, QDIC_OFS_MASK, 32'h1);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h8000);
      ipulse;
      rdchk("cap", QDIC_OFS_CAP, 32'h1234);
      rdchk("cap stat", QDIC_OFS_STAT, 32'h1);
      chk("irq on", 32'h1, {31'h0, irq});
      xfer(1'b1, QDIC_OFS_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      xfer(1'b1, QDIC_OFS_MASK, 32'h1);
      xfer(1'b1, QDIC_OFS_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      xfer(1'b1, QDIC_OFS_POS, 32'h55);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h8040);
      repeat (8) @(posedge pclk);
      rdchk("cap ipol", QDIC_OFS_CAP, 32'h55);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h0);
      $display("t_cap done");
   endtask
   task automatic t_cmp;
      logic [31:0] pv [3] = '{32'h5, 32'ha, 32'h7};
      logic e;
      xfer(1'b1, QDIC_OFS_LOW, 32'h5);
      xfer(1'b1, QDIC_OFS_HIGH, 32'ha);
      for (int p = 0; p < 3; p++) begin
         xfer(1'b1, QDIC_OFS_POS, pv[p]);
         for (int c = 0; c < 4; c++) begin
            xfer(1'b1, QDIC_OFS_IOCL, 32'(c << 9));
            repeat (3) @(posedge pclk);
            e = (c[1] && pv[p] <= 5) || (c[0] && pv[p] >= 10);
            chk("cmp", {31'h0, e}, {31'h0, compare_output_pin});
         end
      end
      // capture flag still set from the polarity capture, plus compare rise
      rdchk("cmp stat", QDIC_OFS_STAT, 32'h3);
      $display("t_cmp done");
   endtask
   task automatic t_filt;
      xfer(1'b1, QDIC_OFS_CTRL, 32'h2);
      xfer(1'b1, QDIC_OFS_POS, 32'h0);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h4000);
      glitch;
      rdchk("glitch flt", QDIC_OFS_POS, 32'h0);
      xfer(1'b1, QDIC_OFS_IOCL, 32'h0);
      glitch;
      rdchk("glitch raw", QDIC_OFS_POS, 32'h1);
      for (int c = 3; c < 7; c++) begin
         xfer(1'b1, QDIC_OFS_IOCL, 32'h4000 | 32'(c << 11));
         repeat (3 * (1 << c) + 12) @(posedge pclk);
         steps(1, 1'b0);
         rdchk("early", QDIC_OFS_IOCL, 32'h4000 | 32'(c << 11));
         repeat (3 * (1 << c) + 12) @(posedge pclk);
         rdchk("late", QDIC_OFS_IOCL, 32'h4001 | 32'(c << 11));
         steps(1, 1'b1);
      end
      $display("t_filt done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_quad;
      t_modes;
      t_cap;
      t_cmp;
      t_filt;
      test_done;
   end
   // the run needs about 1600 cycles; this leaves wide margin
   initial begin
      repeat (40000) @(posedge pclk);
      error_cnt++;
      test_done;
   end
endmodule
bind qdic_top qdic_props u_props (.*);
